/* hdl/pbs_sram.sv */
// Pipelined burst synchronous memory with byte lanes and parity
`timescale 1ns/1ps
`include "pbs_defs.svh"
module pbs_sram #(
   parameter int ADDR_W = `PBS_ADDR_W_WIDE,
   parameter int LANES = `PBS_LANES_WIDE,
   parameter int LANE_W = `PBS_LANE_W,
   parameter int FIFO_DEPTH = `PBS_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic write_n,
   input wire logic advance_or_load,
   input wire logic [LANES-1:0] lane_write_select_n,
   input wire logic select_one_n,
   input wire logic select_two,
   input wire logic select_three_n,
   input wire logic cycle_hold_n,
   input wire logic output_enable_n,
   input wire pbs_pkg::pbs_order_t burst_order,
   input wire logic [LANES*LANE_W-1:0] dq_i,
   input wire logic [LANES-1:0] parity_lines_i,
   output logic [LANES*LANE_W-1:0] dq_o,
   output logic [LANES-1:0] parity_lines_o,
   output logic dq_oe_n
);
   import pbs_pkg::*;
   localparam int LW = LANE_W + 1;
   localparam int W = LANES * LW;
   localparam int BW = `PBS_BURST_W;

   // ***********************************************
   // Input stage
   // ***********************************************
   logic en;
   logic fifo_in_ready;
   logic sel_in;
   pbs_cmd_t s1_cmd_q, s1_cmd_d;
   logic [ADDR_W-1:0] s1_addr_q, s1_addr_d;
   logic [LANES-1:0] s1_mask_q, s1_mask_d;
   logic [BW-1:0] s1_base_q, s1_base_d;
   logic [BW-1:0] s1_cnt_q, s1_cnt_d;
   pbs_cmd_t s2_cmd_q, s2_cmd_d;
   logic [ADDR_W-1:0] s2_addr_q, s2_addr_d;
   logic [LANES-1:0] s2_mask_q, s2_mask_d;

   // A full read buffer stalls the pipeline like a held cycle
   assign en = cycle_hold_n && fifo_in_ready;
   assign sel_in = !select_one_n && select_two && !select_three_n;

   always_comb begin
      s1_cmd_d = s1_cmd_q;
      s1_addr_d = s1_addr_q;
      s1_mask_d = s1_mask_q;
      s1_base_d = s1_base_q;
      s1_cnt_d = s1_cnt_q;
      s2_cmd_d = s2_cmd_q;
      s2_addr_d = s2_addr_q;
      s2_mask_d = s2_mask_q;
      if (en) begin
         s2_cmd_d = s1_cmd_q;
         s2_addr_d = s1_addr_q;
         s2_mask_d = s1_mask_q;
         s1_mask_d = ~lane_write_select_n;
         if (!advance_or_load) begin
            s1_addr_d = addr;
            s1_base_d = addr[BW-1:0];
            s1_cnt_d = '0;
            if (!sel_in) begin
               s1_cmd_d = PBS_IDLE;
            end else if (write_n) begin
               s1_cmd_d = PBS_READ;
            end else begin
               s1_cmd_d = PBS_WRITE;
            end
         end else begin
            s1_cnt_d = s1_cnt_q + 1'b1;
            unique case (burst_order)
               PBS_LINEAR: begin
                  s1_addr_d[BW-1:0] = s1_base_q + s1_cnt_d;
               end
               PBS_INTERLEAVED: begin
                  s1_addr_d[BW-1:0] = s1_base_q ^ s1_cnt_d;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1_cmd_q <= PBS_IDLE;
         s1_addr_q <= '0;
         s1_mask_q <= '0;
         s1_base_q <= '0;
         s1_cnt_q <= '0;
         s2_cmd_q <= PBS_IDLE;
         s2_addr_q <= '0;
         s2_mask_q <= '0;
      end else begin
         s1_cmd_q <= s1_cmd_d;
         s1_addr_q <= s1_addr_d;
         s1_mask_q <= s1_mask_d;
         s1_base_q <= s1_base_d;
         s1_cnt_q <= s1_cnt_d;
         s2_cmd_q <= s2_cmd_d;
         s2_addr_q <= s2_addr_d;
         s2_mask_q <= s2_mask_d;
      end
   end

   // ***********************************************
   // Array and write path
   // ***********************************************
   logic [W-1:0] mem_q [0:(1<<ADDR_W)-1];
   logic [W-1:0] in_word;
   logic [W-1:0] rd_word;
   logic wr_now;
   logic fwd;

   assign wr_now = en && (s2_cmd_q == PBS_WRITE);
   // A read right behind a write to the same word sees the new lanes
   assign fwd = wr_now && (s2_addr_q == s1_addr_q);

   for (genvar g = 0; g < LANES; g++) begin : g_lane
      assign in_word[g*LW +: LW] = {parity_lines_i[g], dq_i[g*LANE_W +: LANE_W]};
      assign rd_word[g*LW +: LW] = (fwd && s2_mask_q[g]) ?
         in_word[g*LW +: LW] : mem_q[s1_addr_q][g*LW +: LW];
   end

   // Write data is taken two enabled edges after its command
   always_ff @(posedge clk) begin
      for (int i = 0; i < LANES; i++) begin
         if (wr_now && s2_mask_q[i]) begin
            mem_q[s2_addr_q][i*LW +: LW] <= in_word[i*LW +: LW];
         end
      end
   end

   // ***********************************************
   // Read buffer and output stage
   // ***********************************************
   logic fifo_out_valid;
   logic [W-1:0] fifo_out_data;
   logic rd_push;
   logic rd_pop;
   logic [W-1:0] out_q, out_d;
   logic drive_q, drive_d;

   assign rd_push = en && (s1_cmd_q == PBS_READ);
   assign rd_pop = en && (s2_cmd_q == PBS_READ) && fifo_out_valid;

   pbs_fifo #(
      .WIDTH(W),
      .DEPTH(FIFO_DEPTH)
   ) u_rd_fifo (
      .clk(clk),
      .rstn(rstn),
      .in_valid(rd_push),
      .in_ready(fifo_in_ready),
      .in_data(rd_word),
      .out_valid(fifo_out_valid),
      .out_ready(rd_pop),
      .out_data(fifo_out_data)
   );

   always_comb begin
      out_d = out_q;
      drive_d = drive_q;
      if (en) begin
         drive_d = (s2_cmd_q == PBS_READ);
         if (rd_pop) begin
            out_d = fifo_out_data;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_q <= '0;
         drive_q <= 1'b0;
      end else begin
         out_q <= out_d;
         drive_q <= drive_d;
      end
   end

   for (genvar g = 0; g < LANES; g++) begin : g_out
      assign dq_o[g*LANE_W +: LANE_W] = out_q[g*LW +: LANE_W];
      assign parity_lines_o[g] = out_q[g*LW + LANE_W];
   end
   // Output enable bypasses the pipeline without a clock
   assign dq_oe_n = !drive_q || output_enable_n;

   // ***********************************************
   // Assertions
   // ***********************************************
   logic ld_read;
   logic ld_write;
   assign ld_read = !advance_or_load && sel_in && write_n;
   assign ld_write = !advance_or_load && sel_in && !write_n;

   a_hold_freeze: assert property (@(posedge clk) disable iff (!rstn)
      !cycle_hold_n |=> $stable(out_q) && $stable(drive_q) && $stable(s1_cmd_q))
      else $error("state moved while cycle held");

   a_read_latency: assert property (@(posedge clk) disable iff (!rstn)
      (en && ld_read) ##1 en ##1 en |=> drive_q && !$stable(drive_q) || drive_q)
      else $error("read data not driven two edges after command");

   a_write_hiz: assert property (@(posedge clk) disable iff (!rstn)
      (en && ld_write) ##1 en ##1 en |=> !drive_q)
      else $error("drivers on during write data cycle");

   a_select_gate: assert property (@(posedge clk) disable iff (!rstn)
      en && !advance_or_load && !sel_in |=> s1_cmd_q == PBS_IDLE)
      else $error("deselected cycle started a command");

   a_oe_async: assert property (@(posedge clk) disable iff (!rstn)
      output_enable_n |-> dq_oe_n)
      else $error("drivers on with output enable high");

   a_lane_mask: assert property (@(posedge clk) disable iff (!rstn)
      en && ld_write |=> s1_mask_q == ~$past(lane_write_select_n))
      else $error("lane selects not captured");

   a_burst_linear: assert property (@(posedge clk) disable iff (!rstn)
      en && advance_or_load && burst_order == PBS_LINEAR
      |=> s1_addr_q[1:0] == 2'($past(s1_base_q) + $past(s1_cnt_q) + 2'h1))
      else $error("linear burst step wrong");

   a_burst_ilv: assert property (@(posedge clk) disable iff (!rstn)
      en && advance_or_load && burst_order == PBS_INTERLEAVED
      |=> s1_addr_q[1:0] == 2'($past(s1_base_q) ^ 2'($past(s1_cnt_q) + 2'h1)))
      else $error("interleaved burst step wrong");

   a_back_to_back: assert property (@(posedge clk) disable iff (!rstn)
      en && !advance_or_load && sel_in ##1 en && !advance_or_load && sel_in
      |=> s2_cmd_q != PBS_IDLE && s1_cmd_q != PBS_IDLE)
      else $error("back to back command dropped");

   a_out_reg: assert property (@(posedge clk) disable iff (!rstn)
      !$stable(out_q) |-> $past(en) && $past(s2_cmd_q) == PBS_READ)
      else $error("output register changed without a read");

   a_addr_capture: assert property (@(posedge clk) disable iff (!rstn)
      en && !advance_or_load |=> s1_addr_q == $past(addr))
      else $error("load address not captured");

   a_cmd_read: assert property (@(posedge clk) disable iff (!rstn)
      en && ld_read |=> s1_cmd_q == PBS_READ)
      else $error("read command not captured");

   a_cmd_write: assert property (@(posedge clk) disable iff (!rstn)
      en && ld_write |=> s1_cmd_q == PBS_WRITE)
      else $error("write command not captured");

   a_write_pipe: assert property (@(posedge clk) disable iff (!rstn)
      (en && ld_write) ##1 en |=> s2_cmd_q == PBS_WRITE)
      else $error("write command not in data stage");

   a_mask_follow: assert property (@(posedge clk) disable iff (!rstn)
      en |=> s2_mask_q == $past(s1_mask_q))
      else $error("lane selects lost between stages");

   a_no_stall: assert property (@(posedge clk) disable iff (!rstn)
      fifo_in_ready)
      else $error("read buffer full, pipeline stalled");

   a_hold_pipe: assert property (@(posedge clk) disable iff (!rstn)
      !cycle_hold_n |=> $stable(s2_cmd_q) && $stable(s1_addr_q) && $stable(s2_addr_q))
      else $error("pipeline moved while cycle held");

   a_drive_sel: assert property (@(posedge clk) disable iff (!rstn)
      en |=> drive_q == ($past(s2_cmd_q) == PBS_READ))
      else $error("driver state not from pipeline");

   a_out_load: assert property (@(posedge clk) disable iff (!rstn)
      rd_pop |=> out_q == $past(fifo_out_data))
      else $error("output register missed read data");

   a_burst_cmd: assert property (@(posedge clk) disable iff (!rstn)
      en && advance_or_load |=> s1_cmd_q == $past(s1_cmd_q))
      else $error("burst changed command type");

   a_burst_upper: assert property (@(posedge clk) disable iff (!rstn)
      en && advance_or_load |=> s1_addr_q[ADDR_W-1:BW] == $past(s1_addr_q[ADDR_W-1:BW]))
      else $error("burst moved upper address bits");

   a_oe_drive: assert property (@(posedge clk) disable iff (!rstn)
      !output_enable_n && drive_q |-> !dq_oe_n)
      else $error("drivers off with output enable low");

endmodule : pbs_sram

/* hdl/pbs_defs.svh */
// Constants for the pipelined burst synchronous memory
`ifndef PBS_DEFS_SVH
`define PBS_DEFS_SVH
`define PBS_ADDR_W_WIDE 18
`define PBS_ADDR_W_NARROW 19
`define PBS_LANES_WIDE 4
`define PBS_LANES_NARROW 2
`define PBS_LANE_W 8
`define PBS_BURST_W 2
`define PBS_FIFO_DEPTH 8
`define PBS_CLK_PERIOD_NS 5
`endif

/* hdl/pbs_pkg.sv */
// Types for the pipelined burst synchronous memory
package pbs_pkg;
   typedef enum logic [1:0] {
      PBS_IDLE = 2'b00,
      PBS_READ = 2'b01,
      PBS_WRITE = 2'b10
   } pbs_cmd_t;
   typedef enum logic {
      PBS_LINEAR = 1'b0,
      PBS_INTERLEAVED = 1'b1
   } pbs_order_t;
endpackage : pbs_pkg

/* hdl/pbs_fifo.sv */
// Word FIFO with valid and ready on both sides
`timescale 1ns/1ps
module pbs_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   logic [WIDTH-1:0] store_q [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;
   // Depth must be a power of two so the pointers wrap naturally
   assign in_ready = cnt_q != FULL;
   assign out_valid = cnt_q != '0;
   assign out_data = store_q[rp_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_comb begin
      wp_d = push ? wp_q + 1'b1 : wp_q;
      rp_d = pop ? rp_q + 1'b1 : rp_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
   end
   always_ff @(posedge clk) begin
      if (push) begin
         store_q[wp_q] <= in_data;
      end
   end
endmodule : pbs_fifo

/* test/pbs_ctrl_model.sv */
// Controller-side model that drives write data two enabled edges after a write
`timescale 1ns/1ps
module pbs_ctrl_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cycle_hold_n,
   input wire logic wr_cmd,
   input wire logic [35:0] wr_word,
   output logic [31:0] dq_i,
   output logic [3:0] parity_lines_i
);
   logic [1:0] v_q;
   logic [35:0] d1_q, d2_q, last_q;
   // ****************************
   // Write data pipe, frozen on hold
   // ****************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         v_q <= 2'h0;
         last_q <= 36'h0;
      end else if (cycle_hold_n) begin
         v_q <= {v_q[0], wr_cmd};
         d1_q <= wr_word;
         d2_q <= d1_q;
         if (v_q[0]) begin
            last_q <= d1_q;
         end
      end
   end
   // Released bus shows the inverse of the last word
   assign {parity_lines_i, dq_i} = v_q[1] ? d2_q : ~last_q;
endmodule : pbs_ctrl_model

/* test/pbs_sram_tb_top.sv */
// Self-checking testbench for the pipelined burst synchronous memory
`timescale 1ns/1ps
module pbs_sram_tb_top;
   import pbs_pkg::*;
   typedef struct packed {
      logic v;
      logic w;
      logic [17:0] a;
      logic [3:0] ln;
      logic [35:0] d;
   } pbs_item_t;
   logic clk = 0, rstn = 0, write_n = 1, advance_or_load = 0, select_one_n = 1;
   logic select_two = 1, select_three_n = 0, cycle_hold_n = 1, output_enable_n = 0, dq_oe_n;
   logic [17:0] addr = 18'h0, base = 18'h0;
   logic [3:0] lane_write_select_n = 4'hf, parity_lines_i, parity_lines_o;
   logic [31:0] dq_i, dq_o;
   logic [36:0] last = '0;
   logic [7:0] salt = 8'h0;
   pbs_order_t burst_order = PBS_LINEAR;
   pbs_item_t nxt = '0, p1 = '0, p2 = '0, s;
   logic [35:0] mem [logic [17:0]];
   int err_total = 0, cmp_count = 0, n = 0;
   pbs_sram DUT (.clk(clk), .rstn(rstn), .addr(addr), .write_n(write_n),
      .advance_or_load(advance_or_load), .lane_write_select_n(lane_write_select_n),
      .select_one_n(select_one_n), .select_two(select_two), .select_three_n(select_three_n),
      .cycle_hold_n(cycle_hold_n), .output_enable_n(output_enable_n),
      .burst_order(burst_order), .dq_i(dq_i), .parity_lines_i(parity_lines_i),
      .dq_o(dq_o), .parity_lines_o(parity_lines_o), .dq_oe_n(dq_oe_n));
   pbs_ctrl_model ctrl (.clk(clk), .rstn(rstn), .cycle_hold_n(cycle_hold_n),
      .wr_cmd(nxt.v && nxt.w), .wr_word(nxt.d), .dq_i(dq_i), .parity_lines_i(parity_lines_i));
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [36:0] seen, input logic [36:0] want);
      cmp_count++;
      if (seen !== want) begin
         err_total++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
      end
   endtask : chk
   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim
   // ****************************
   // One command per cycle; burst address tracked here
   // ****************************
   task automatic cmd(input logic w, input logic adv, input logic [17:0] a,
                      input logic [3:0] ln, input logic [2:0] cs);
      pbs_item_t it;
      it = nxt;
      if (adv) begin
         n = n + 1;
         it.a[1:0] = (burst_order == PBS_INTERLEAVED) ? base[1:0] ^ 2'(n) : base[1:0] + 2'(n);
      end else begin
         base = a;
         n = 0;
         it = {cs == 3'b010, w, a, 4'h0, 36'h0};
      end
      it.ln = ln;
      it.d = {it.a[3:0] ^ salt[3:0], salt, 6'h0, it.a};
      {select_one_n, select_two, select_three_n} <= cs;
      advance_or_load <= adv;
      addr <= a;
      write_n <= !w;
      lane_write_select_n <= ln;
      nxt <= it;
      @(posedge clk);
   endtask : cmd
   task automatic idle(input int k);
      repeat (k) cmd(1'b0, 1'b0, 18'h0, 4'hf, 3'b110);
   endtask : idle
   // ****************************
   // Reference pipeline and output comparison
   // ****************************
   always @(posedge clk) begin
      if (rstn && cycle_hold_n) begin
         s = p2;
         for (int g = 0; g < 4; g++) begin
            if (s.v && s.w && !s.ln[g]) begin
               mem[s.a][g*8+:8] = s.d[g*8+:8];
               mem[s.a][32+g] = s.d[32+g];
            end
         end
         p2 <= p1;
         p1 <= nxt;
         #1;
         chk(dq_oe_n, !(s.v && !s.w) | output_enable_n);
         if (s.v && !s.w && !output_enable_n) begin
            chk({parity_lines_o, dq_o}, mem[s.a]);
         end
         last = {dq_oe_n, parity_lines_o, dq_o};
      end else if (rstn) begin
         #1;
         chk({dq_oe_n, parity_lines_o, dq_o}, last);
      end
   end
   task automatic t_rw;
      for (int i = 0; i < 4; i++) cmd(1'b1, 1'b0, 18'(i), 4'h0, 3'b010);
      for (int i = 0; i < 4; i++) begin
         cmd(1'b0, 1'b0, 18'(i), 4'h0, 3'b010);
         cmd(1'b1, 1'b0, 18'(i + 4), 4'h0, 3'b010);
         cmd(1'b0, 1'b0, 18'(i + 4), 4'h0, 3'b010);
      end
      idle(3);
   endtask : t_rw
   task automatic t_lanes;
      salt = 8'h3c;
      cmd(1'b1, 1'b0, 18'h1, 4'b1010, 3'b010);
      cmd(1'b1, 1'b0, 18'h2, 4'b0101, 3'b010);
      cmd(1'b0, 1'b0, 18'h2, 4'h0, 3'b010);
      cmd(1'b0, 1'b0, 18'h1, 4'h0, 3'b010);
      idle(3);
   endtask : t_lanes
   task automatic t_burst;
      for (int o = 0; o < 2; o++) begin
         burst_order <= pbs_order_t'(o);
         salt = 8'(8'h50 + o);
         @(posedge clk);
         cmd(1'b1, 1'b0, 18'h11, 4'h0, 3'b010);
         repeat (4) cmd(1'b1, 1'b1, 18'h0, 4'h0, 3'b010);
         cmd(1'b0, 1'b0, 18'h12, 4'h0, 3'b010);
         repeat (4) cmd(1'b0, 1'b1, 18'h0, 4'h0, 3'b010);
         idle(3);
      end
   endtask : t_burst
   task automatic t_desel;
      salt = 8'ha5;
      cmd(1'b1, 1'b0, 18'h0, 4'h0, 3'b110);
      cmd(1'b1, 1'b0, 18'h0, 4'h0, 3'b000);
      cmd(1'b1, 1'b0, 18'h0, 4'h0, 3'b011);
      cmd(1'b0, 1'b1, 18'h0, 4'h0, 3'b010);
      cmd(1'b0, 1'b0, 18'h0, 4'h0, 3'b010);
      idle(3);
   endtask : t_desel
   task automatic t_hold;
      salt = 8'h77;
      cmd(1'b1, 1'b0, 18'h3, 4'h0, 3'b010);
      cmd(1'b0, 1'b0, 18'h0, 4'h0, 3'b010);
      cycle_hold_n <= 1'b0;
      repeat (3) @(posedge clk);
      cycle_hold_n <= 1'b1;
      cmd(1'b0, 1'b0, 18'h3, 4'h0, 3'b010);
      cmd(1'b0, 1'b0, 18'h2, 4'h0, 3'b010);
      idle(3);
   endtask : t_hold
   task automatic t_oe;
      cmd(1'b0, 1'b0, 18'h1, 4'h0, 3'b010);
      cmd(1'b0, 1'b0, 18'h2, 4'h0, 3'b010);
      idle(1);
      output_enable_n <= 1'b1;
      idle(1);
      output_enable_n <= 1'b0;
      idle(2);
   endtask : t_oe
   initial begin
      repeat (4) @(posedge clk);
      chk({dq_oe_n, parity_lines_o, dq_o}, {1'b1, 36'h0});
      rstn <= 1'b1;
      @(posedge clk);
      t_rw;
      t_lanes;
      t_burst;
      t_desel;
      t_hold;
      t_oe;
      end_sim;
   end
   initial begin
      repeat (2000) @(posedge clk);
      err_total++;
      end_sim;
   end
endmodule : pbs_sram_tb_top
